// File: core/dcd_pkg.sv
// constants, carriers and state layout for the dma command decoder
package dcd_pkg;

  // command register
  localparam logic [7:0] CMD_REG_OFFSET = 8'h30;
  localparam logic [7:0] CMD_READ_VALUE = 8'hff;

  // command codes
  localparam logic [7:0] CMD_GEN_IN = 8'h00;
  localparam logic [7:0] CMD_GEN_OUT = 8'h01;
  localparam logic [7:0] CMD_MW_IN = 8'h06;
  localparam logic [7:0] CMD_MW_OUT = 8'h07;
  localparam logic [7:0] CMD_PIO_DATA = 8'h0a;
  localparam logic [7:0] CMD_POLL = 8'h0b;
  localparam logic [7:0] CMD_TASK_RD = 8'h0c;
  localparam logic [7:0] CMD_VALIDATE = 8'h0e;
  localparam logic [7:0] CMD_CLEAR = 8'h0f;
  localparam logic [7:0] CMD_RESTART = 8'h10;
  localparam logic [7:0] CMD_CORE_RST = 8'h11;
  localparam logic [7:0] CMD_MW_ABORT = 8'h12;
  localparam logic [7:0] CMD_GEN_ABORT = 8'h13;

  // task file addresses
  localparam logic [9:0] TF_DATA = 10'h1f0;
  localparam logic [9:0] TF_STATUS = 10'h1f7;
  localparam logic [9:0] TF_CNT_LO = 10'h1f4;
  localparam logic [9:0] TF_CNT_HI = 10'h1f5;
  localparam int BSY_BIT = 7;
  // task file sweep, all but 1F0/1F7, entry 0 first
  localparam logic [7:0][9:0] TF_LIST = {10'h3f7, 10'h3f6, 10'h1f6,
    10'h1f5, 10'h1f4, 10'h1f3, 10'h1f2, 10'h1f1};
  localparam logic [2:0] TF_LAST = 3'h7;

  // widths
  localparam int WORD_W = 16;
  localparam int CYC_W = 8;

  // timing
  localparam int CLK_NS = 20;
  localparam int PIO_STROBE_NS = 100;
  localparam int MW_STROBE_NS = 80;
  localparam int RECOVER_NS = 40;
  localparam logic [CYC_W-1:0] PIO_STROBE_CYC =
    CYC_W'((PIO_STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CYC_W-1:0] MW_STROBE_CYC =
    CYC_W'((MW_STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CYC_W-1:0] RECOVER_CYC =
    CYC_W'((RECOVER_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [2:0] {
    ST_IDLE, ST_GEN_IN, ST_GEN_OUT, ST_MW_IN, ST_MW_OUT, ST_PIO
  } dcd_state_type;

  typedef enum logic [1:0] {PK_DATA, PK_POLL, PK_TASK} dcd_pio_type;

  typedef enum logic [1:0] {PH_WAIT, PH_STROBE, PH_RECOVER} dcd_phase_type;

  // handshake lines, all active high
  typedef struct packed {
    logic req;
    logic ack;
    logic rd;
    logic wr;
  } dcd_hs_type;

  // endpoint buffer control pulses
  typedef struct packed {
    logic validate;
    logic tx_flush;
    logic restart;
    logic in_commit;
  } dcd_ep_type;

  typedef struct packed {
    dcd_state_type st;
    dcd_pio_type pk;
    dcd_phase_type ph;
    dcd_hs_type hs;
    dcd_ep_type ep;
    logic [WORD_W-1:0] bus_data;
    logic bus_oe_n;
    logic [9:0] addr;
    logic [CYC_W-1:0] cyc;
    logic [WORD_W-1:0] words;
    logic have_word;
    logic src_ready;
    logic [2:0] tidx;
    logic single;
    logic ext_rd_q;
    logic ext_wr_q;
    logic [1:0][WORD_W-1:0] fifo_d;
    logic [1:0] fifo_v;
    logic int_st;
    logic irq;
    logic [WORD_W-1:0] task_data;
    logic [9:0] task_sel;
    logic task_valid;
    logic core_rst;
    logic active;
    logic [7:0] cmd_rdata;
  } dcd_regs_type;

endpackage

// File: core/dcd_top.sv
// dma command decoder: decodes command bytes and runs the transfers
//
// Function
// - 00h: slave transfer, bus into buffer
// - 01h: slave transfer, buffer onto bus
// - 06h/07h: multi-word transfer in, out
// - 0Ah: PIO reads of data register
// - 0Bh: repeatedly read status, watch busy
// - busy clear ends polling, sets completion
// - mask gates output only, status still sets
// - 0Ch index zero: sweep all but 1F0/1F7
// - 0Ch nonzero index: read that register only
// - task reads done: set completion, interrupt
// - 0Eh: validate endpoint buffer
// - 0Fh: flush indexed transmit buffer only
// - transmit buffer empties itself after sending
// - 10h: rewind endpoint buffer pointers
// - 11h: core back to power-on state
// - core reset may pulse handshake lines
// - 12h: abort multi-word transfers only
// - write-only command byte reads FFh
// - PIO transfers are always 16 bit
// - data bus undriven until a command runs
// - 13h: stop slave transfer, commit, complete
`timescale 1ns/100ps
module dcd_top
(
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // command port
  input wire logic i_cmd_wr,
  input wire logic [7:0] i_cmd_code,
  output logic [7:0] o_cmd_rdata,
  // configuration and status
  input wire logic [3:0] i_task_index,
  input wire logic [15:0] i_byte_count,
  input wire logic [15:0] i_xfer_words,
  input wire logic i_int_mask,
  input wire logic i_int_clr,
  output logic o_int_status,
  output logic o_irq,
  output logic o_active,
  output logic o_core_reset,
  // external bus
  input wire logic i_xfer_ack,
  input wire logic i_ext_rd,
  input wire logic i_ext_wr,
  input wire logic i_dev_req,
  input wire logic [15:0] i_bus_data,
  output logic [15:0] o_bus_data,
  output logic o_bus_oe_n,
  output logic [9:0] o_task_addr,
  output dcd_pkg::dcd_hs_type o_hs,
  // task file results
  output logic [15:0] o_task_data,
  output logic [9:0] o_task_sel,
  output logic o_task_valid,
  // words from the bus toward the endpoint buffer
  output logic o_ep_valid,
  output logic [15:0] o_ep_data,
  input wire logic i_ep_ready,
  // words from the endpoint buffer toward the bus
  input wire logic i_src_valid,
  input wire logic [15:0] i_src_data,
  output logic o_src_ready,
  // endpoint buffer controls
  output dcd_pkg::dcd_ep_type o_ep
);

  localparam dcd_pkg::dcd_regs_type RST_VAL = '{
    st: dcd_pkg::ST_IDLE,
    pk: dcd_pkg::PK_DATA,
    ph: dcd_pkg::PH_WAIT,
    hs: '0,
    ep: '0,
    bus_data: '0,
    bus_oe_n: 1'b1,
    addr: '0,
    cyc: '0,
    words: '0,
    have_word: 1'b0,
    src_ready: 1'b0,
    tidx: '0,
    single: 1'b0,
    ext_rd_q: 1'b0,
    ext_wr_q: 1'b0,
    fifo_d: '0,
    fifo_v: '0,
    int_st: 1'b0,
    irq: 1'b0,
    task_data: '0,
    task_sel: '0,
    task_valid: 1'b0,
    core_rst: 1'b0,
    active: 1'b0,
    cmd_rdata: dcd_pkg::CMD_READ_VALUE
  };

  dcd_pkg::dcd_regs_type r_r;
  dcd_pkg::dcd_regs_type r_nxt;

  always_comb
  begin
    logic push;
    logic room;
    logic done;
    logic [15:0] push_d;
    logic [1:0] v;
    logic [1:0][15:0] d;
    push = 1'b0;
    done = 1'b0;
    push_d = i_bus_data;
    room = ~r_r.fifo_v[1];
    v = r_r.fifo_v;
    d = r_r.fifo_d;
    r_nxt = r_r;
    // pulses last one cycle
    r_nxt.ep = '0;
    r_nxt.task_valid = 1'b0;
    r_nxt.core_rst = 1'b0;
    r_nxt.src_ready = 1'b0;
    r_nxt.cmd_rdata = dcd_pkg::CMD_READ_VALUE;
    r_nxt.ext_rd_q = i_ext_rd;
    r_nxt.ext_wr_q = i_ext_wr;

    case (r_r.st)
      dcd_pkg::ST_GEN_IN:
      begin
        if (i_ext_wr && !r_r.ext_wr_q && i_xfer_ack && room)
          push = 1'b1;
      end
      dcd_pkg::ST_GEN_OUT:
      begin
        r_nxt.src_ready = ~r_r.have_word & ~r_r.src_ready;
        if (r_r.src_ready && i_src_valid)
        begin
          r_nxt.bus_data = i_src_data;
          r_nxt.have_word = 1'b1;
        end
        r_nxt.hs.req = r_nxt.have_word;
        // word is gone once the external read strobe ends
        if (!i_ext_rd && r_r.ext_rd_q && i_xfer_ack)
        begin
          r_nxt.have_word = 1'b0;
          r_nxt.hs.req = 1'b0;
        end
      end
      dcd_pkg::ST_MW_IN, dcd_pkg::ST_MW_OUT:
      begin
        if (r_r.st == dcd_pkg::ST_MW_OUT)
        begin
          r_nxt.src_ready = ~r_r.have_word & ~r_r.src_ready;
          if (r_r.src_ready && i_src_valid)
          begin
            r_nxt.bus_data = i_src_data;
            r_nxt.have_word = 1'b1;
          end
        end
        case (r_r.ph)
          dcd_pkg::PH_WAIT:
            if (i_dev_req && ((r_r.st == dcd_pkg::ST_MW_IN) ? room
                : r_r.have_word))
            begin
              r_nxt.ph = dcd_pkg::PH_STROBE;
              r_nxt.cyc = dcd_pkg::MW_STROBE_CYC;
              r_nxt.hs.ack = 1'b1;
              r_nxt.hs.rd = (r_r.st == dcd_pkg::ST_MW_IN);
              r_nxt.hs.wr = (r_r.st == dcd_pkg::ST_MW_OUT);
            end
          dcd_pkg::PH_STROBE:
            if (r_r.cyc == 8'h01)
            begin
              r_nxt.hs.rd = 1'b0;
              r_nxt.hs.wr = 1'b0;
              r_nxt.ph = dcd_pkg::PH_RECOVER;
              r_nxt.cyc = dcd_pkg::RECOVER_CYC;
              r_nxt.words = r_r.words - 16'h0001;
              if (r_r.st == dcd_pkg::ST_MW_IN)
                push = 1'b1;
              else
                r_nxt.have_word = 1'b0;
              if (r_r.words == 16'h0001)
                done = 1'b1;
            end
            else
              r_nxt.cyc = r_r.cyc - 8'h01;
          default:
            if (r_r.cyc == 8'h01)
            begin
              r_nxt.ph = dcd_pkg::PH_WAIT;
              r_nxt.hs.ack = 1'b0;
            end
            else
              r_nxt.cyc = r_r.cyc - 8'h01;
        endcase
      end
      dcd_pkg::ST_PIO:
        case (r_r.ph)
          dcd_pkg::PH_WAIT:
            // data reads wait for buffer room, the others never stall
            if (room || r_r.pk != dcd_pkg::PK_DATA)
            begin
              r_nxt.ph = dcd_pkg::PH_STROBE;
              r_nxt.cyc = dcd_pkg::PIO_STROBE_CYC;
              r_nxt.hs.rd = 1'b1;
            end
          dcd_pkg::PH_STROBE:
            if (r_r.cyc == 8'h01)
            begin
              r_nxt.hs.rd = 1'b0;
              r_nxt.ph = dcd_pkg::PH_RECOVER;
              r_nxt.cyc = dcd_pkg::RECOVER_CYC;
              case (r_r.pk)
                dcd_pkg::PK_DATA:
                begin
                  push = 1'b1;
                  r_nxt.words = r_r.words - 16'h0001;
                  if (r_r.words == 16'h0001)
                    done = 1'b1;
                end
                dcd_pkg::PK_POLL:
                  if (!i_bus_data[dcd_pkg::BSY_BIT])
                    done = 1'b1;
                default:
                begin
                  r_nxt.task_data = i_bus_data;
                  r_nxt.task_sel = r_r.addr;
                  r_nxt.task_valid = 1'b1;
                  if (r_r.single || r_r.tidx == dcd_pkg::TF_LAST)
                    done = 1'b1;
                  else
                  begin
                    r_nxt.tidx = r_r.tidx + 3'h1;
                    r_nxt.addr = dcd_pkg::TF_LIST[r_nxt.tidx];
                  end
                end
              endcase
            end
            else
              r_nxt.cyc = r_r.cyc - 8'h01;
          default:
            if (r_r.cyc == 8'h01)
              r_nxt.ph = dcd_pkg::PH_WAIT;
            else
              r_nxt.cyc = r_r.cyc - 8'h01;
        endcase
      default:
        // idle drives no handshake, which also ends the reset blip
        r_nxt.hs = '0;
    endcase

    if (done)
    begin
      // hardware set of completion happens below, after any clear
      r_nxt.st = dcd_pkg::ST_IDLE;
      r_nxt.hs = '0;
      r_nxt.ph = dcd_pkg::PH_WAIT;
      r_nxt.bus_oe_n = 1'b1;
    end

    // command decode; stops and reset act at any time
    if (i_cmd_wr)
      case (i_cmd_code)
        dcd_pkg::CMD_GEN_IN, dcd_pkg::CMD_GEN_OUT,
        dcd_pkg::CMD_MW_IN, dcd_pkg::CMD_MW_OUT:
          if (r_r.st == dcd_pkg::ST_IDLE &&
              (i_cmd_code[2:1] == 2'b00 || i_xfer_words != 16'h0000))
          begin
            r_nxt.st = (i_cmd_code == dcd_pkg::CMD_GEN_IN) ?
              dcd_pkg::ST_GEN_IN : (i_cmd_code == dcd_pkg::CMD_GEN_OUT) ?
              dcd_pkg::ST_GEN_OUT : (i_cmd_code == dcd_pkg::CMD_MW_IN) ?
              dcd_pkg::ST_MW_IN : dcd_pkg::ST_MW_OUT;
            r_nxt.words = i_xfer_words;
            r_nxt.ph = dcd_pkg::PH_WAIT;
            r_nxt.have_word = 1'b0;
            // drive the bus only while words flow outward
            r_nxt.bus_oe_n = ~i_cmd_code[0];
          end
        dcd_pkg::CMD_PIO_DATA, dcd_pkg::CMD_POLL, dcd_pkg::CMD_TASK_RD:
          if (r_r.st == dcd_pkg::ST_IDLE)
          begin
            r_nxt.st = dcd_pkg::ST_PIO;
            r_nxt.ph = dcd_pkg::PH_WAIT;
            r_nxt.tidx = 3'h0;
            r_nxt.single = (i_task_index != 4'h0);
            // byte count is set up by software before this command
            r_nxt.words = 16'((17'(i_byte_count) + 17'h1) >> 1);
            if (i_cmd_code == dcd_pkg::CMD_PIO_DATA)
            begin
              r_nxt.pk = dcd_pkg::PK_DATA;
              r_nxt.addr = dcd_pkg::TF_DATA;
              if (i_byte_count == 16'h0000)
                r_nxt.st = dcd_pkg::ST_IDLE;
            end
            else if (i_cmd_code == dcd_pkg::CMD_POLL)
            begin
              r_nxt.pk = dcd_pkg::PK_POLL;
              r_nxt.addr = dcd_pkg::TF_STATUS;
            end
            else
            begin
              r_nxt.pk = dcd_pkg::PK_TASK;
              r_nxt.addr = (i_task_index != 4'h0) ?
                10'(dcd_pkg::TF_DATA + {6'h00, i_task_index})
                : dcd_pkg::TF_LIST[0];
            end
          end
        dcd_pkg::CMD_VALIDATE:
          r_nxt.ep.validate = 1'b1;
        // only forced clearing; normal emptying is the buffer's own job
        dcd_pkg::CMD_CLEAR:
          r_nxt.ep.tx_flush = 1'b1;
        dcd_pkg::CMD_RESTART:
          r_nxt.ep.restart = 1'b1;
        dcd_pkg::CMD_MW_ABORT:
          if (r_r.st == dcd_pkg::ST_MW_IN || r_r.st == dcd_pkg::ST_MW_OUT)
          begin
            r_nxt.st = dcd_pkg::ST_IDLE;
            r_nxt.hs = '0;
            r_nxt.ph = dcd_pkg::PH_WAIT;
            r_nxt.bus_oe_n = 1'b1;
          end
        dcd_pkg::CMD_GEN_ABORT:
          if (r_r.st == dcd_pkg::ST_GEN_IN || r_r.st == dcd_pkg::ST_GEN_OUT)
          begin
            r_nxt.st = dcd_pkg::ST_IDLE;
            r_nxt.hs = '0;
            r_nxt.bus_oe_n = 1'b1;
            r_nxt.ep.in_commit = 1'b1;
            done = 1'b1;
          end
        default:
        begin
          // reserved codes fall here and touch nothing
        end
      endcase

    // buffer: pop from the head, then append at the first free entry
    if (r_r.fifo_v[0] && i_ep_ready)
    begin
      d[0] = d[1];
      v = {1'b0, v[1]};
    end
    if (push)
    begin
      if (!v[0])
      begin
        d[0] = push_d;
        v[0] = 1'b1;
      end
      else
      begin
        d[1] = push_d;
        v[1] = 1'b1;
      end
    end
    r_nxt.fifo_d = d;
    r_nxt.fifo_v = v;
    // request follows the room left after this edge, so no word is lost
    if (r_nxt.st == dcd_pkg::ST_GEN_IN)
      r_nxt.hs.req = ~v[1];

    // a completion in the same cycle as a clear is kept
    r_nxt.int_st = (r_r.int_st & ~i_int_clr) | done;
    r_nxt.irq = r_nxt.int_st & ~i_int_mask;
    r_nxt.active = (r_nxt.st != dcd_pkg::ST_IDLE);

    // whole core back to power-on values, lines blip for one cycle
    if (i_cmd_wr && i_cmd_code == dcd_pkg::CMD_CORE_RST)
    begin
      r_nxt = RST_VAL;
      r_nxt.hs = '1;
      r_nxt.core_rst = 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      r_r <= RST_VAL;
    else if (i_ce)
      r_r <= r_nxt;
  end

  assign o_cmd_rdata = r_r.cmd_rdata;
  assign o_int_status = r_r.int_st;
  assign o_irq = r_r.irq;
  assign o_active = r_r.active;
  assign o_core_reset = r_r.core_rst;
  assign o_bus_data = r_r.bus_data;
  assign o_bus_oe_n = r_r.bus_oe_n;
  assign o_task_addr = r_r.addr;
  assign o_hs = r_r.hs;
  assign o_task_data = r_r.task_data;
  assign o_task_sel = r_r.task_sel;
  assign o_task_valid = r_r.task_valid;
  assign o_ep_valid = r_r.fifo_v[0];
  assign o_ep_data = r_r.fifo_d[0];
  assign o_src_ready = r_r.src_ready;
  assign o_ep = r_r.ep;

endmodule

// File: verif/dcd_top_props.sv
// port assertions for the dma command decoder
`timescale 1ns/100ps
module dcd_props_chk
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // command side
  input wire logic i_cmd_wr,
  input wire logic [7:0] i_cmd_code,
  input wire logic [3:0] i_task_index,
  input wire logic i_int_mask,
  input wire logic [7:0] o_cmd_rdata,
  input wire logic o_irq,
  input wire logic o_active,
  input wire logic o_core_reset,
  // bus side
  input wire logic [9:0] o_task_addr,
  input wire dcd_pkg::dcd_hs_type o_hs,
  input wire dcd_pkg::dcd_ep_type o_ep
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  logic go;
  assign go = i_ce && i_cmd_wr && !o_active;
  rdata_ones_a: assert property (o_cmd_rdata == 8'hff)
    else $error("command read value wrong");
  ep_validate_a: assert property (
    go && i_cmd_code == 8'h0e |=> o_ep == 4'h8) else $error("no validate");
  ep_flush_a: assert property (
    go && i_cmd_code == 8'h0f |=> o_ep == 4'h4) else $error("no flush");
  ep_rewind_a: assert property (
    go && i_cmd_code == 8'h10 |=> o_ep == 4'h2) else $error("no restart");
  core_rst_a: assert property (
    go && i_cmd_code == 8'h11 |=> o_core_reset && o_hs == 4'hf
    ##1 !o_core_reset && !o_active) else $error("core reset wrong");
  reserved_quiet_a: assert property (
    go && i_cmd_code inside {8'h02, 8'h03, 8'h04, 8'h05, 8'h0d, 8'h12}
    |=> !o_active && o_ep == 4'h0) else $error("reserved code acted");
  pio_addr_a: assert property (
    go && i_cmd_code == 8'h0a |=> o_active && o_task_addr == 10'h1f0)
    else $error("data read address wrong");
  poll_addr_a: assert property (
    go && i_cmd_code == 8'h0b |=> o_active && o_task_addr == 10'h1f7)
    else $error("poll address wrong");
  single_rd_a: assert property (
    go && i_cmd_code == 8'h0c && i_task_index != 4'h0
    |=> o_task_addr == 10'h1f0 + {6'h0, $past(i_task_index)})
    else $error("single read address wrong");
  irq_mask_a: assert property ($past(i_int_mask) |-> !o_irq)
    else $error("masked irq raised");
endmodule

bind dcd_top dcd_props_chk chk_u
(
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_cmd_wr(i_cmd_wr),
  .i_cmd_code(i_cmd_code), .i_task_index(i_task_index),
  .i_int_mask(i_int_mask), .o_cmd_rdata(o_cmd_rdata), .o_irq(o_irq),
  .o_active(o_active), .o_core_reset(o_core_reset),
  .o_task_addr(o_task_addr), .o_hs(o_hs), .o_ep(o_ep)
);

// File: verif/dcd_far_model.sv
// far side model: task file device and multiword requester
`timescale 1ns/100ps
module dcd_far_model
(
  // clock and bench controls
  input wire logic i_clk,
  input wire logic i_req_en,
  input wire logic i_busy_load,
  input wire logic [3:0] i_busy_reads,
  // from the decoder
  input wire dcd_pkg::dcd_hs_type i_hs,
  input wire logic [9:0] i_addr,
  input wire logic i_oe_n,
  // toward the decoder
  output logic [15:0] o_data,
  output logic o_dev_req,
  output logic o_xfer_ack
);
  logic [3:0] busy_r = 4'h0;
  logic rd_q = 1'b0;
  logic [15:0] last_r = 16'h0;
  logic [15:0] pio_val;
  always_comb
  begin
    pio_val = {~i_addr[7:0], i_addr[7:0]};
    if (i_addr == 10'h1f7)
      pio_val[7] = (busy_r != 4'h0);
  end
  // released bus flips every cycle so a late sample cannot match
  always_comb
  begin
    if (i_hs.rd && !i_hs.ack)
      o_data = pio_val;
    else if (i_hs.ack && i_oe_n)
      o_data = 16'h3c5a;
    else
      o_data = ~last_r;
  end
  always @(posedge i_clk)
  begin
    last_r <= o_data;
    rd_q <= i_hs.rd;
    if (i_busy_load)
      busy_r <= i_busy_reads;
    else if (rd_q && !i_hs.rd && i_addr == 10'h1f7 && busy_r != 4'h0)
      busy_r <= busy_r - 4'h1;
  end
  assign o_dev_req = i_req_en;
  assign o_xfer_ack = i_hs.req;
endmodule

// File: verif/test_dma_command_decoder.sv
// self-checking bench for the dma command decoder
`timescale 1ns/100ps
module test_dma_command_decoder;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_ce = 1'b1;
  logic i_cmd_wr = 1'b0;
  logic [7:0] i_cmd_code = 8'h00;
  logic [3:0] i_task_index = 4'h0;
  logic [15:0] i_byte_count = 16'h0;
  logic [15:0] i_xfer_words = 16'h0;
  logic i_int_mask = 1'b0;
  logic i_int_clr = 1'b0;
  logic i_ep_ready = 1'b0;
  logic req_en = 1'b0;
  logic busy_load = 1'b0;
  logic [3:0] busy_reads = 4'h0;
  logic hold = 1'b1;
  logic [7:0] rnd = 8'h5c;
  logic [9:0] a;
  logic ext_rd = 1'b0;
  logic ext_wr = 1'b0;
  logic wr_q = 1'b0;
  logic [15:0] gen_word = 16'h0;
  logic [7:0] o_cmd_rdata;
  logic o_int_status, o_irq, o_active, o_core_reset, xfer_ack, dev_req;
  logic o_bus_oe_n, o_task_valid, o_ep_valid, o_src_ready;
  logic [15:0] bus_in, far_data, o_bus_data, o_task_data, o_ep_data;
  logic [9:0] o_task_addr, o_task_sel;
  dcd_pkg::dcd_hs_type o_hs;
  dcd_pkg::dcd_ep_type o_ep;
  int failures = 0;
  int checked = 0;
  int nw;
  logic [25:0] task_q[$];
  logic [25:0] word_q[$];
  logic [25:0] ep_q[$];
  logic [7:0] ep_codes[4] = '{8'h0e, 8'h0f, 8'h0f, 8'h10};
  logic [7:0] bad[8] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h0d, 8'h06, 8'h12,
    8'h13};
  assign bus_in = o_bus_oe_n ? (ext_wr ? gen_word : far_data) : o_bus_data;
  dcd_top dut_u
  (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_cmd_wr(i_cmd_wr),
    .i_cmd_code(i_cmd_code), .o_cmd_rdata(o_cmd_rdata),
    .i_task_index(i_task_index), .i_byte_count(i_byte_count),
    .i_xfer_words(i_xfer_words), .i_int_mask(i_int_mask),
    .i_int_clr(i_int_clr), .o_int_status(o_int_status), .o_irq(o_irq),
    .o_active(o_active), .o_core_reset(o_core_reset),
    .i_xfer_ack(xfer_ack), .i_ext_rd(ext_rd), .i_ext_wr(ext_wr),
    .i_dev_req(dev_req), .i_bus_data(bus_in), .o_bus_data(o_bus_data),
    .o_bus_oe_n(o_bus_oe_n), .o_task_addr(o_task_addr), .o_hs(o_hs),
    .o_task_data(o_task_data), .o_task_sel(o_task_sel),
    .o_task_valid(o_task_valid), .o_ep_valid(o_ep_valid),
    .o_ep_data(o_ep_data), .i_ep_ready(i_ep_ready), .i_src_valid(rnd[1]),
    .i_src_data(gen_word), .o_src_ready(o_src_ready), .o_ep(o_ep)
  );
  dcd_far_model far_u
  (
    .i_clk(i_clk), .i_req_en(req_en), .i_busy_load(busy_load),
    .i_busy_reads(busy_reads), .i_hs(o_hs), .i_addr(o_task_addr),
    .i_oe_n(o_bus_oe_n), .o_data(far_data), .o_dev_req(dev_req),
    .o_xfer_ack(xfer_ack)
  );
  initial
  begin
    forever #10 i_clk = ~i_clk;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [15:0] tf_val(input logic [9:0] ad);
    logic [15:0] v;
    v = {~ad[7:0], ad[7:0]};
    if (ad == 10'h1f7)
      v[7] = 1'b0;
    return v;
  endfunction
  // an empty queue yields unknown, so an unexpected result always fails
  function automatic logic [25:0] pop(ref logic [25:0] q[$]);
    return q.size() > 0 ? q.pop_front() : 'x;
  endfunction
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_task(input logic [25:0] e, input logic [25:0] g);
    chk({6'h0, e}, {6'h0, g});
  endtask
  task automatic cmp_word(input logic [25:0] e, input logic [15:0] g);
    chk({6'h0, e}, {16'h0, g});
  endtask
  task automatic cmp_ep(input logic [25:0] e, input logic [3:0] g);
    chk({6'h0, e}, {28'h0, g});
  endtask
  task automatic test_done();
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] c);
    @(negedge i_clk);
    i_cmd_wr = 1'b1;
    i_cmd_code = c;
    @(negedge i_clk);
    i_cmd_wr = 1'b0;
  endtask
  task automatic wait_idle();
    for (int n = 0; n < 4000 && o_active !== 1'b0; n++)
      @(negedge i_clk);
    @(negedge i_clk);
    chk(32'h0, {31'h0, o_active});
  endtask
  task automatic clr_int();
    i_int_clr = 1'b1;
    @(negedge i_clk);
    i_int_clr = 1'b0;
    chk(32'h0, {30'h0, o_int_status, o_irq});
  endtask
  // external controller strobe; one idle cycle after so the edge is seen
  task automatic ext_strobe(input logic rd, input logic [15:0] w);
    while (o_hs.req !== 1'b1)
      @(negedge i_clk);
    gen_word = w;
    ext_rd = rd;
    ext_wr = !rd;
    @(negedge i_clk);
    ext_rd = 1'b0;
    ext_wr = 1'b0;
    @(negedge i_clk);
  endtask
  always @(posedge i_clk)
  begin
    if (i_rst_n && o_task_valid === 1'b1)
      cmp_task(pop(task_q), {o_task_sel, o_task_data});
    if (i_rst_n && o_ep_valid === 1'b1 && i_ep_ready)
      cmp_word(pop(word_q), o_ep_data);
    if (i_rst_n && o_ep !== 4'h0)
      cmp_ep(pop(ep_q), o_ep);
    if (i_rst_n && o_bus_oe_n === 1'b0 &&
        (ext_rd || o_hs.wr === 1'b1 && !wr_q))
      cmp_word(pop(word_q), o_bus_data);
    wr_q <= o_hs.wr;
  end
  always @(negedge i_clk)
  begin
    rnd <= lfsr(rnd);
    i_ep_ready <= !hold && rnd[0];
  end
  initial
  begin
    #400000;
    failures++;
    test_done();
  end
  initial
  begin
    repeat (6) @(negedge i_clk);
    i_rst_n = 1'b1;
    chk(32'hff, {24'h0, o_cmd_rdata});
    chk(32'h1, {31'h0, o_bus_oe_n});
    hold = 1'b0;
    foreach (ep_codes[i])
    begin
      ep_q.push_back(ep_codes[i] == 8'h0e ? 26'h8 :
        ep_codes[i] == 8'h0f ? 26'h4 : 26'h2);
      cmd(ep_codes[i]);
    end
    @(negedge i_clk);
    i_ce = 1'b0;
    cmd(8'h0e);
    i_ce = 1'b1;
    chk(32'h0, {28'h0, o_ep});
    foreach (bad[i])
    begin
      cmd(bad[i]);
      chk(32'h0, {31'h0, o_active});
    end
    i_int_mask = 1'b1;
    for (int i = 0; i < 8; i++)
      task_q.push_back({dcd_pkg::TF_LIST[i], tf_val(dcd_pkg::TF_LIST[i])});
    cmd(8'h0c);
    wait_idle();
    chk(32'h2, {30'h0, o_int_status, o_irq});
    i_int_mask = 1'b0;
    @(negedge i_clk);
    chk(32'h3, {30'h0, o_int_status, o_irq});
    clr_int();
    i_task_index = 4'(rnd % 8'd7) + 4'h1;
    a = 10'h1f0 + {6'h0, i_task_index};
    task_q.push_back({a, tf_val(a)});
    cmd(8'h0c);
    wait_idle();
    chk(32'h3, {30'h0, o_int_status, o_irq});
    clr_int();
    busy_reads = 4'h3;
    busy_load = 1'b1;
    @(negedge i_clk);
    busy_load = 1'b0;
    cmd(8'h0b);
    wait_idle();
    chk(32'h3, {30'h0, o_int_status, o_irq});
    clr_int();
    hold = 1'b1;
    i_byte_count = {13'h0, rnd[2:0]} + 16'h5;
    nw = (int'(i_byte_count) + 1) / 2;
    repeat (nw) word_q.push_back({10'h0, tf_val(10'h1f0)});
    cmd(8'h0a);
    repeat (60) @(negedge i_clk);
    chk(32'h1, {31'h0, o_active});
    hold = 1'b0;
    wait_idle();
    chk(32'h1, {31'h0, o_int_status});
    clr_int();
    i_xfer_words = 16'h2;
    req_en = 1'b1;
    repeat (2) word_q.push_back({10'h0, 16'h3c5a});
    cmd(8'h06);
    wait_idle();
    // far side requester off for the slave transfers
    req_en = 1'b0;
    chk(32'h1, {31'h0, o_int_status});
    clr_int();
    cmd(8'h00);
    repeat (3)
    begin
      word_q.push_back({10'h0, rnd, ~rnd});
      ext_strobe(1'b0, {rnd, ~rnd});
    end
    ep_q.push_back(26'h1);
    cmd(8'h13);
    chk(32'h1, {30'h0, o_active, o_int_status});
    clr_int();
    while (word_q.size() != 0)
      @(negedge i_clk);
    gen_word = 16'hc3a5;
    cmd(8'h01);
    repeat (3)
    begin
      word_q.push_back({10'h0, gen_word});
      ext_strobe(1'b1, {rnd, ~rnd});
    end
    ep_q.push_back(26'h1);
    cmd(8'h13);
    chk(32'h1, {30'h0, o_active, o_int_status});
    clr_int();
    gen_word = 16'h5a3c;
    req_en = 1'b1;
    repeat (2) word_q.push_back({10'h0, 16'h5a3c});
    cmd(8'h07);
    wait_idle();
    chk(32'h1, {31'h0, o_int_status});
    clr_int();
    req_en = 1'b0;
    cmd(8'h06);
    chk(32'h1, {31'h0, o_active});
    cmd(8'h12);
    chk(32'h0, {30'h0, o_active, o_int_status});
    cmd(8'h11);
    chk(32'h1f, {27'h0, o_core_reset, o_hs});
    @(negedge i_clk);
    chk(32'h1, {26'h0, o_core_reset, o_hs, o_int_status,
      o_bus_oe_n});
    repeat (4) @(negedge i_clk);
    chk(32'h0, task_q.size() + word_q.size() + ep_q.size());
    test_done();
  end
endmodule
